/* rtl/dcsm_defs.vh */
`ifndef DCSM_DEFS_VH
`define DCSM_DEFS_VH
// Clock rate in Hz
`define DCSM_CLK_HZ 40000000
// Synchronization time, ms (plain default)
`define DCSM_SYNC_MS 500
// Signal interlock monitoring time, ms
`define DCSM_SIL_MS 200
// Interlock release time, ms (one second)
`define DCSM_REL_MS 1000
// Response time, ms (plain default)
`define DCSM_RESP_MS 20
// Activation delay, ms (plain default)
`define DCSM_ACT_MS 50
// Cycle counts derived from the rate
`define DCSM_SYNC_CYC ((`DCSM_CLK_HZ / 1000) * `DCSM_SYNC_MS)
`define DCSM_SIL_CYC ((`DCSM_CLK_HZ / 1000) * `DCSM_SIL_MS)
`define DCSM_REL_CYC ((`DCSM_CLK_HZ / 1000) * `DCSM_REL_MS)
`define DCSM_RESP_CYC ((`DCSM_CLK_HZ / 1000) * `DCSM_RESP_MS)
`define DCSM_ACT_CYC ((`DCSM_CLK_HZ / 1000) * `DCSM_ACT_MS)
// Counter width
`define DCSM_CNT_W 26
`endif

/* rtl/dcsm_sync.v */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Three-stage input synchronizer with agreement filter
// ------------------------------------------------------------
module dcsm_sync
(
   input wire clk,
   input wire srst,
   input wire din,
   output reg dout
);
   reg s1_reg; // Metastability stage, read only by s2
   reg s2_reg; // Second stage
   reg s3_reg; // Third stage

   // Shift chain; output moves once stages two and three agree
   always @(posedge clk)
   begin
      if (srst)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
         begin
            dout <= s3_reg;
         end
      end
   end
endmodule

/* rtl/dcsm_monitor.v */
`timescale 1ns/10ps
`include "dcsm_defs.vh"
// Contract
// - Sync mode: both channels active within window
// - No start: output stays off
// - Start met: energize within activation delay
// - Channel drop: de-energize within response time
// - Antivalent: first low, second high is active
// - Antivalent equal levels alert beyond sync time
// - Antivalent evaluation only when mode selects it
// - Second stays active past 200 ms: alert
// - First reactivates before second drops: alert now
// - Interlock clears after one second both off
// - Sync failure keeps outputs de-energized
module dcsm_monitor
#(
   parameter SYNC_CYC = `DCSM_SYNC_CYC,
   parameter SIL_CYC = `DCSM_SIL_CYC,
   parameter REL_CYC = `DCSM_REL_CYC,
   parameter RESP_CYC = `DCSM_RESP_CYC,
   parameter ACT_CYC = `DCSM_ACT_CYC
)
(
   input wire CLK,
   input wire SRST,
   input wire FIRST_CHANNEL_NO_TERMINAL,
   input wire SECOND_CHANNEL_NC_TERMINAL,
   input wire START_IN,
   input wire MODE_ANTIVALENT,
   input wire MODE_SYNC,
   input wire MODE_INTERLOCK,
   output reg SAFETY_OUT,
   output reg ALERT_EQUAL,
   output reg ALERT_INTERLOCK,
   output reg ALERT_SYNC
);
   // ------------------------------------------------------------
   // Constants
   // ------------------------------------------------------------
   localparam W = `DCSM_CNT_W;
   localparam [W-1:0] SYNC_LIM = SYNC_CYC[W-1:0];
   localparam [W-1:0] SIL_LIM = SIL_CYC[W-1:0];
   localparam [W-1:0] REL_LIM = REL_CYC[W-1:0];
   localparam [W-1:0] RESP_LIM = RESP_CYC[W-1:0];
   localparam [W-1:0] ACT_LIM = ACT_CYC[W-1:0];
   localparam [1:0] ST_OFF = 2'h0; // Run, outputs de-energized
   localparam [1:0] ST_ARM = 2'h1; // Start met, activation pending
   localparam [1:0] ST_ON = 2'h2; // Run, outputs energized

   // Saturating increment
   function [W-1:0] inc;
      input [W-1:0] v;
      begin
         inc = (v == {W{1'b1}}) ? v : v + {{(W-1){1'b0}}, 1'b1};
      end
   endfunction

   // ------------------------------------------------------------
   // Synchronizers
   // ------------------------------------------------------------
   wire t1_s; // First terminal, synchronized
   wire t2_s; // Second terminal, synchronized
   wire st_s; // Start, synchronized

   dcsm_sync u_sync1 (.clk(CLK), .srst(SRST), .din(FIRST_CHANNEL_NO_TERMINAL), .dout(t1_s));
   dcsm_sync u_sync2 (.clk(CLK), .srst(SRST), .din(SECOND_CHANNEL_NC_TERMINAL), .dout(t2_s));
   dcsm_sync u_sync3 (.clk(CLK), .srst(SRST), .din(START_IN), .dout(st_s));

   // ------------------------------------------------------------
   // Channel decode
   // ------------------------------------------------------------
   wire ch1_act; // Channel one activated
   wire ch2_act; // Channel two activated
   wire equal_lv; // Antivalent pair at equal levels

   // Antivalent: first low and second high means activated
   assign ch1_act = MODE_ANTIVALENT ? ~t1_s : t1_s;
   assign ch2_act = t2_s;
   assign equal_lv = MODE_ANTIVALENT & (t1_s == t2_s);
   wire both_act = ch1_act & ch2_act; // Whole input activated
   wire any_off = ~ch1_act | ~ch2_act; // Some channel dropped
   wire none_act = ~ch1_act & ~ch2_act; // Both channels dropped

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [1:0] state_reg; // Output state
   reg [W-1:0] eq_cnt_reg; // Equal-level time
   reg [W-1:0] syn_cnt_reg; // Time since first channel activated
   reg sync_ok_reg; // Both channels came in within window
   reg [W-1:0] sil_cnt_reg; // Time since first channel dropped
   reg sil_run_reg; // Interlock window open
   reg both_seen_reg; // Full activation seen since both last off
   reg [W-1:0] rel_cnt_reg; // Both-off time for interlock release
   reg [W-1:0] act_cnt_reg; // Activation delay
   reg [W-1:0] resp_cnt_reg; // Time since a channel dropped while on

   // ------------------------------------------------------------
   // Equal-level monitor
   // ------------------------------------------------------------
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         eq_cnt_reg <= {W{1'b0}};
         ALERT_EQUAL <= 1'b0;
      end
      else if (!equal_lv)
      begin
         // Distinct levels restart the window
         eq_cnt_reg <= {W{1'b0}};
         ALERT_EQUAL <= 1'b0;
      end
      else
      begin
         eq_cnt_reg <= inc(eq_cnt_reg);
         if (eq_cnt_reg >= SYNC_LIM)
         begin
            ALERT_EQUAL <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Synchronization check
   // ------------------------------------------------------------
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         syn_cnt_reg <= {W{1'b0}};
         sync_ok_reg <= 1'b0;
         both_seen_reg <= 1'b0;
         ALERT_SYNC <= 1'b0;
      end
      else if (none_act)
      begin
         // Both off: arm for a fresh activation
         syn_cnt_reg <= {W{1'b0}};
         sync_ok_reg <= 1'b0;
         both_seen_reg <= 1'b0;
         ALERT_SYNC <= 1'b0;
      end
      else if (!both_act)
      begin
         // One channel in, waiting for the other
         syn_cnt_reg <= inc(syn_cnt_reg);
         sync_ok_reg <= 1'b0;
         if (syn_cnt_reg >= SYNC_LIM)
         begin
            ALERT_SYNC <= MODE_SYNC;
         end
      end
      else
      begin
         // Only the first full activation after both off may qualify
         both_seen_reg <= 1'b1;
         if (!sync_ok_reg && !both_seen_reg && !ALERT_SYNC && syn_cnt_reg <= SYNC_LIM)
         begin
            sync_ok_reg <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Signal interlock monitor
   // ------------------------------------------------------------
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         sil_cnt_reg <= {W{1'b0}};
         sil_run_reg <= 1'b0;
         rel_cnt_reg <= {W{1'b0}};
         ALERT_INTERLOCK <= 1'b0;
      end
      else if (!MODE_INTERLOCK)
      begin
         sil_run_reg <= 1'b0;
         ALERT_INTERLOCK <= 1'b0;
      end
      else
      begin
         // Window opens when exactly one channel drops from active
         if (!sil_run_reg && both_seen_reg && any_off && !none_act && !ALERT_INTERLOCK)
         begin
            sil_run_reg <= 1'b1;
            sil_cnt_reg <= {W{1'b0}};
         end
         else if (sil_run_reg)
         begin
            sil_cnt_reg <= inc(sil_cnt_reg);
            if (none_act)
            begin
               sil_run_reg <= 1'b0;
            end
            else if (both_act)
            begin
               sil_run_reg <= 1'b0;
               ALERT_INTERLOCK <= 1'b1;
            end
            else if (sil_cnt_reg >= SIL_LIM)
            begin
               sil_run_reg <= 1'b0;
               ALERT_INTERLOCK <= 1'b1;
            end
         end
         // Release needs both channels off for the full time
         if (none_act)
         begin
            rel_cnt_reg <= inc(rel_cnt_reg);
            if (ALERT_INTERLOCK && rel_cnt_reg >= REL_LIM)
            begin
               ALERT_INTERLOCK <= 1'b0;
            end
         end
         else
         begin
            rel_cnt_reg <= {W{1'b0}};
         end
      end
   end

   // ------------------------------------------------------------
   // Output state machine
   // ------------------------------------------------------------
   wire checks_ok = both_act & ~ALERT_EQUAL & ~ALERT_INTERLOCK
                    & ~(MODE_SYNC & ~sync_ok_reg);
   reg [1:0] state_next;

   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF:
         begin
            if (st_s && checks_ok)
            begin
               state_next = ST_ARM;
            end
         end
         ST_ARM:
         begin
            if (!checks_ok)
            begin
               state_next = ST_OFF;
            end
            else if (act_cnt_reg >= ACT_LIM - 1'b1)
            begin
               state_next = ST_ON;
            end
         end
         ST_ON:
         begin
            // Start is not looked at here
            if (!checks_ok && (ALERT_EQUAL || ALERT_INTERLOCK
                || resp_cnt_reg >= RESP_LIM - 1'b1 || !both_act))
            begin
               state_next = ST_OFF;
            end
         end
         default:
         begin
            state_next = ST_OFF;
         end
      endcase
   end

   // State, delay counters and output flop
   always @(posedge CLK)
   begin
      if (SRST)
      begin
         state_reg <= ST_OFF;
         act_cnt_reg <= {W{1'b0}};
         resp_cnt_reg <= {W{1'b0}};
         SAFETY_OUT <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         act_cnt_reg <= (state_reg == ST_ARM) ? inc(act_cnt_reg) : {W{1'b0}};
         resp_cnt_reg <= (state_reg == ST_ON && any_off) ? inc(resp_cnt_reg) : {W{1'b0}};
         SAFETY_OUT <= (state_next == ST_ON);
      end
   end
endmodule

/* tb/dcsm_chk.sv */
`timescale 1ns/10ps
// --------------------------------
// Port checker for the monitor
// --------------------------------
module dcsm_chk
#(
   parameter int SYNC_CYC = 20,
   parameter int REL_CYC = 40,
   parameter int RESP_CYC = 8
)
(
   input wire CLK,
   input wire SRST,
   input wire FIRST_CHANNEL_NO_TERMINAL,
   input wire SECOND_CHANNEL_NC_TERMINAL,
   input wire START_IN,
   input wire MODE_ANTIVALENT,
   input wire MODE_SYNC,
   input wire MODE_INTERLOCK,
   input wire SAFETY_OUT,
   input wire ALERT_EQUAL,
   input wire ALERT_INTERLOCK,
   input wire ALERT_SYNC
);
   // Channel one seen active high
   wire f_w = FIRST_CHANNEL_NO_TERMINAL ^ MODE_ANTIVALENT;
   wire s_w = SECOND_CHANNEL_NC_TERMINAL;
   logic [7:0] st_reg, eq_reg, off_reg, act_reg;
   // Saturating run counter
   function automatic logic [7:0] inc(input logic [7:0] v, input logic c);
      inc = c ? v + {7'h00, v != 8'hFF} : 8'h00;
   endfunction
   // Cycles since start, equal levels, both off, both on
   always @(posedge CLK)
   begin
      st_reg <= SRST ? 8'hFF : inc(st_reg, !START_IN);
      eq_reg <= SRST ? 8'h00 : inc(eq_reg, f_w != s_w);
      off_reg <= SRST ? 8'h00 : inc(off_reg, !f_w && !s_w);
      act_reg <= SRST ? 8'h00 : inc(act_reg, f_w && s_w);
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   AST_RISE_OK:
   assert property ($rose(SAFETY_OUT) |-> !(ALERT_SYNC || ALERT_INTERLOCK))
      else $error("Output rose during alert");
   AST_SYNC_OFF:
   assert property (ALERT_SYNC |-> !SAFETY_OUT) else $error("Output on with sync alert");
   AST_IL_OFF:
   assert property (ALERT_INTERLOCK |-> !SAFETY_OUT) else $error("Output on with interlock");
   AST_DROP:
   assert property (SAFETY_OUT && !(f_w && s_w) |-> ##[1:RESP_CYC] !SAFETY_OUT)
      else $error("Output late to drop");
   AST_START_SRC:
   assert property ($rose(SAFETY_OUT) |-> st_reg < 30) else $error("Output rose without start");
   AST_START_REL:
   assert property (SAFETY_OUT && $fell(START_IN) && act_reg > 8 |=> SAFETY_OUT)
      else $error("Start release dropped output");
   AST_EQ_MODE:
   assert property (!MODE_ANTIVALENT |-> !ALERT_EQUAL) else $error("Equal alert out of mode");
   AST_EQ_LATE:
   assert property (MODE_ANTIVALENT && eq_reg == SYNC_CYC + 8 |-> ALERT_EQUAL)
      else $error("Equal alert missing");
   AST_EQ_EARLY:
   assert property ($rose(ALERT_EQUAL) |-> eq_reg >= SYNC_CYC) else $error("Equal alert early");
   AST_IL_REL:
   assert property ($fell(ALERT_INTERLOCK) |-> off_reg >= REL_CYC)
      else $error("Interlock cleared early");
endmodule
bind dcsm_monitor dcsm_chk #(.SYNC_CYC(SYNC_CYC), .REL_CYC(REL_CYC), .RESP_CYC(RESP_CYC)) u_chk
(
   .CLK(CLK), .SRST(SRST), .FIRST_CHANNEL_NO_TERMINAL(FIRST_CHANNEL_NO_TERMINAL),
   .SECOND_CHANNEL_NC_TERMINAL(SECOND_CHANNEL_NC_TERMINAL), .START_IN(START_IN),
   .MODE_ANTIVALENT(MODE_ANTIVALENT), .MODE_SYNC(MODE_SYNC), .MODE_INTERLOCK(MODE_INTERLOCK),
   .SAFETY_OUT(SAFETY_OUT), .ALERT_EQUAL(ALERT_EQUAL), .ALERT_INTERLOCK(ALERT_INTERLOCK),
   .ALERT_SYNC(ALERT_SYNC)
);

/* tb/dcsm_contacts.sv */
`timescale 1ns/10ps
// --------------------------------
// Contact pair and start button
// --------------------------------
module dcsm_contacts
(
   input wire on_a,
   input wire on_b,
   input wire push,
   input wire anti,
   output wire pin_a,
   output wire pin_b,
   output wire pin_st
);
   // With anti set, the normally open first contact reads low when closed
   assign pin_a = on_a ^ anti;
   assign pin_b = on_b;
   assign pin_st = push;
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
// --------------------------------
// Self-checking bench
// --------------------------------
module tb_top;
   localparam int SYNC = 20, SIL = 30, REL = 40, RESP = 8, ACT = 5;
   logic clk = 1'b0, srst = 1'b1, on_a = 1'b0, on_b = 1'b0, push = 1'b0;
   logic anti = 1'b0, syn = 1'b0, il = 1'b0;
   wire pa, pb, ps, so, ae, ai, as;
   int miscompares = 0, checks = 0, n;
   always #12.5 clk = ~clk;
   dcsm_contacts u_ct (.on_a(on_a), .on_b(on_b), .push(push), .anti(anti), .pin_a(pa),
      .pin_b(pb), .pin_st(ps));
   dcsm_monitor #(.SYNC_CYC(SYNC), .SIL_CYC(SIL), .REL_CYC(REL), .RESP_CYC(RESP),
      .ACT_CYC(ACT)) DUT (.CLK(clk), .SRST(srst), .FIRST_CHANNEL_NO_TERMINAL(pa),
      .SECOND_CHANNEL_NC_TERMINAL(pb), .START_IN(ps), .MODE_ANTIVALENT(anti),
      .MODE_SYNC(syn), .MODE_INTERLOCK(il), .SAFETY_OUT(so), .ALERT_EQUAL(ae),
      .ALERT_INTERLOCK(ai), .ALERT_SYNC(as));
   // Verdict and end of run
   task close_out;
      $display("Checks %0d mismatches %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Compare one value
   task chk(input string nm, input logic s, input logic e);
      checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("Error %s expected %b seen %b", nm, e, s);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   // Bounded wait for the output level
   task wait_out(input logic v, input int lim);
      n = 0;
      while (so !== v && n < lim)
      begin
         cyc(1);
         n++;
      end
      chk("SAFETY_OUT wait", so, v);
      // Bound used up: go straight to the report
      if (so !== v)
      begin
         close_out;
      end
   endtask
   // Reset with modes and contacts open
   task rst(input logic a, input logic s, input logic l);
      srst = 1'b1;
      {anti, syn, il, on_a, on_b, push} = {a, s, l, 3'h0};
      cyc(2);
      srst = 1'b0;
      cyc(6);
   endtask
   task sc_basic;
      rst(1'b0, 1'b0, 1'b0);
      {on_a, on_b} = 2'h3;
      cyc(30);
      chk("SAFETY_OUT idle", so, 1'b0);
      chk("ALERT_EQUAL plain idle", ae, 1'b0);
      push = 1'b1;
      wait_out(1'b1, 20);
      chk("activation delay", n <= ACT + 8, 1'b1);
      push = 1'b0;
      cyc(20);
      chk("SAFETY_OUT held", so, 1'b1);
      on_b = 1'b0;
      wait_out(1'b0, RESP);
      {on_a, on_b, push} = 3'h3;
      cyc(20);
      chk("SAFETY_OUT plain", so, 1'b0);
      chk("ALERT_EQUAL plain", ae, 1'b0);
   endtask
   task sc_anti;
      rst(1'b1, 1'b0, 1'b0);
      {on_a, on_b, push} = 3'h7;
      wait_out(1'b1, 20);
      {on_a, on_b, push} = 3'h0;
      wait_out(1'b0, RESP);
      on_a = 1'b1;
      cyc(SYNC - 6);
      chk("ALERT_EQUAL early", ae, 1'b0);
      cyc(16);
      chk("ALERT_EQUAL late", ae, 1'b1);
   endtask
   task sc_sync;
      rst(1'b0, 1'b1, 1'b0);
      on_a = 1'b1;
      cyc(SYNC + 10);
      {on_b, push} = 2'h3;
      cyc(20);
      chk("SAFETY_OUT unsynced", so, 1'b0);
      chk("ALERT_SYNC", as, 1'b1);
      {on_a, on_b, push} = 3'h0;
      cyc(10);
      {on_a, on_b, push} = 3'h7;
      wait_out(1'b1, 20);
      on_b = 1'b0;
      cyc(SYNC + 10);
      on_b = 1'b1;
      cyc(20);
      chk("SAFETY_OUT resync", so, 1'b0);
      chk("ALERT_SYNC resync", as, 1'b1);
   endtask
   task sc_lock;
      rst(1'b0, 1'b0, 1'b1);
      on_a = 1'b1;
      cyc(3);
      {on_b, push} = 2'h3;
      wait_out(1'b1, 20);
      chk("ALERT_INTERLOCK stagger", ai, 1'b0);
      on_a = 1'b0;
      cyc(3);
      on_b = 1'b0;
      cyc(20);
      chk("ALERT_INTERLOCK kept", ai, 1'b0);
      {on_a, on_b} = 2'h3;
      wait_out(1'b1, 20);
      on_a = 1'b0;
      cyc(SIL + 8);
      chk("ALERT_INTERLOCK late", ai, 1'b1);
      chk("SAFETY_OUT locked", so, 1'b0);
      on_b = 1'b0;
      cyc(REL / 2);
      chk("ALERT_INTERLOCK held", ai, 1'b1);
      cyc(REL / 2 + 12);
      chk("ALERT_INTERLOCK freed", ai, 1'b0);
      {on_a, on_b} = 2'h3;
      wait_out(1'b1, 20);
      on_a = 1'b0;
      cyc(6);
      on_a = 1'b1;
      cyc(8);
      chk("ALERT_INTERLOCK now", ai, 1'b1);
   endtask
   initial
   begin
      sc_basic;
      sc_anti;
      sc_sync;
      sc_lock;
      close_out;
   end
endmodule
